// ### verilog/lpc_lane_power.sv
// lane power control: per pair activity of an lvds transmitter and reserved-slot fill
// assumes config ports static-ish, sequencer power state and pixel bits synchronous to clk_sys_in
`timescale 1ns/1ps
module lpc_lane_power (
	// clock and reset
	input  wire logic                clk_sys_in,
	input  wire logic                rst_n_in,
	// configuration fields
	input  wire logic [1:0]          first_channel_activity_in,
	input  wire logic [1:0]          eighth_bit_pair_activity_in,
	input  wire logic [1:0]          second_clock_activity_in,
	input  wire logic [1:0]          second_channel_activity_in,
	input  wire logic                idle_tristate_sel_in,
	input  wire logic                reserved_dup_sel_in,
	// power sequencer: high while panel powered on
	input  wire logic                panel_power_on_in,
	// reserved-slot source bit per channel
	input  wire logic [1:0]          dup_data_bit_in,
	// outputs
	output lpc_pkg::lpc_pair_t       pair_state_out [lpc_pkg::LPC_NPAIR],
	output logic [1:0]               reserved_slot_out,
	output logic                     eight_bit_mode_out,
	output logic                     two_channel_mode_out
);
	import lpc_pkg::*;

	typedef struct packed {
		lpc_state_t            st;
		lpc_pair_t [LPC_NPAIR-1:0] pair;
		logic [1:0]            rsv;
		logic                  eight;
		logic                  two;
	} lpc_regs_t;

	lpc_regs_t state_reg;
	lpc_regs_t state_next;

	// combine two caps: the lower level wins
	function automatic logic [1:0] lpc_min(input logic [1:0] a, input logic [1:0] b);
		lpc_min = (a < b) ? a : b;
	endfunction

	function automatic lpc_pair_t lpc_level(input logic [1:0] lvl);
		case (lvl)
			LPC_ACT_ACTIVE: lpc_level = LPC_PAIR_ACTIVE;
			LPC_ACT_DATA0:  lpc_level = LPC_PAIR_ZERO;
			LPC_ACT_RSVD:   lpc_level = LPC_PAIR_OFF;
			default:        lpc_level = LPC_PAIR_OFF;
		endcase
	endfunction

	logic [1:0] lvl_a;
	logic [1:0] lvl_b;
	logic [1:0] lvl_a3;
	logic [1:0] lvl_b3;
	logic [1:0] lvl_second_clock_pair;
	logic [1:0] cap [LPC_NPAIR];
	lpc_pair_t  idle_lvl;

	always_comb begin
		lvl_a    = first_channel_activity_in;
		lvl_b    = second_channel_activity_in;
		lvl_a3   = lpc_min(eighth_bit_pair_activity_in, lvl_a);
		lvl_b3   = lpc_min(eighth_bit_pair_activity_in, lvl_b);
		// second clock follows its own field only in two-channel mode
		lvl_second_clock_pair = (lvl_b == LPC_ACT_ACTIVE) ? lpc_min(second_clock_activity_in, lvl_b) : lvl_b;
		cap[LPC_A0]   = lvl_a;
		cap[LPC_A1]   = lvl_a;
		cap[LPC_A2]   = lvl_a;
		// clock stays running at data-zero level
		cap[LPC_FIRST_CLOCK_PAIR] = (lvl_a == LPC_ACT_DATA0) ? LPC_ACT_ACTIVE : lvl_a;
		cap[LPC_A3]   = lvl_a3;
		cap[LPC_B0]   = lvl_b;
		cap[LPC_B1]   = lvl_b;
		cap[LPC_B2]   = lvl_b;
		cap[LPC_B3]   = lvl_b3;
		cap[LPC_SECOND_CLOCK_PAIR] = lvl_second_clock_pair;
		// idle style, only used while the sequencer holds the panel off
		idle_lvl = (idle_tristate_sel_in == LPC_IDLE_ZERO) ? LPC_PAIR_OFF : LPC_PAIR_HIZ;
	end

	always_comb begin
		state_next = state_reg;
		state_next.st = panel_power_on_in ? LPC_ST_ON : LPC_ST_OFF;
		for (int i = 0; i < LPC_NPAIR; i++) begin
			case (state_next.st)
				LPC_ST_ON: state_next.pair[i] = lpc_level(cap[i]);
				LPC_ST_OFF: begin
					// idle style applies only to sequencer power-down
					state_next.pair[i] = idle_lvl;
				end
				default: state_next.pair[i] = LPC_PAIR_OFF;
			endcase
		end
		for (int c = 0; c < 2; c++) begin
			state_next.rsv[c] = (reserved_dup_sel_in == LPC_RSV_ZERO) ? 1'h0 : dup_data_bit_in[c];
		end
		state_next.eight = (eighth_bit_pair_activity_in != LPC_ACT_DOWN);
		state_next.two   = (lvl_b == LPC_ACT_ACTIVE);
		if (!rst_n_in) begin
			state_next.st    = LPC_ST_OFF;
			for (int i = 0; i < LPC_NPAIR; i++) begin
				state_next.pair[i] = LPC_PAIR_OFF;
			end
			state_next.rsv   = '0;
			state_next.eight = 1'h0;
			state_next.two   = 1'h0;
		end
	end

	always_ff @(posedge clk_sys_in) begin
		state_reg <= state_next;
	end

	generate
		for (genvar g = 0; g < LPC_NPAIR; g++) begin : g_out
			assign pair_state_out[g] = state_reg.pair[g];
		end
	endgenerate
	assign reserved_slot_out    = state_reg.rsv;
	assign eight_bit_mode_out   = state_reg.eight;
	assign two_channel_mode_out = state_reg.two;

	// checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);

	// per pair view of the registered outputs, for the checks that span all pairs
	logic [LPC_NPAIR-1:0] pair_is_off;
	logic [LPC_NPAIR-1:0] pair_is_hiz;
	logic [LPC_NPAIR-1:0] pair_is_up;

	generate
		for (genvar g = 0; g < LPC_NPAIR; g++) begin : g_view
			assign pair_is_off[g] = (pair_state_out[g] == LPC_PAIR_OFF);
			assign pair_is_hiz[g] = (pair_state_out[g] == LPC_PAIR_HIZ);
			assign pair_is_up[g]  = (pair_state_out[g] == LPC_PAIR_ZERO) || (pair_state_out[g] == LPC_PAIR_ACTIVE);
		end
	endgenerate

	// reserved slot fill
	chk_rsv_zero_fill: assert property (reserved_dup_sel_in == LPC_RSV_ZERO |=> reserved_slot_out == 2'h0)
		else $error("reserved slot not zero");
	chk_rsv_dup_fill: assert property (reserved_dup_sel_in != LPC_RSV_ZERO
		|=> reserved_slot_out == $past(dup_data_bit_in))
		else $error("reserved slot not duplicate");

	// sequencer power-down and idle buffer style
	chk_idle_buffer_style: assert property (!panel_power_on_in
		|=> pair_state_out[LPC_A0] == ($past(idle_tristate_sel_in) ? LPC_PAIR_HIZ : LPC_PAIR_OFF))
		else $error("idle buffer state wrong");
	chk_idle_all_pairs: assert property (!panel_power_on_in
		|=> ($past(idle_tristate_sel_in) ? (&pair_is_hiz) : (&pair_is_off)))
		else $error("idle style not on every pair");
	chk_hiz_only_seq: assert property (panel_power_on_in |=> pair_state_out[LPC_B0] != LPC_PAIR_HIZ)
		else $error("tristate outside sequenced off");
	chk_hiz_none_on: assert property (panel_power_on_in |=> pair_is_hiz == '0)
		else $error("tristate pair while powered on");
	chk_seq_override: assert property (!panel_power_on_in |=> pair_state_out[LPC_FIRST_CLOCK_PAIR] != LPC_PAIR_ACTIVE)
		else $error("sequencer off did not override");
	chk_seq_all_down: assert property (!panel_power_on_in |=> pair_is_up == '0)
		else $error("pair powered up while sequencer off");

	// first channel
	chk_first_down: assert property (panel_power_on_in && first_channel_activity_in == LPC_ACT_DOWN
		|=> pair_state_out[LPC_A3] == LPC_PAIR_OFF && pair_state_out[LPC_FIRST_CLOCK_PAIR] == LPC_PAIR_OFF
		&& pair_state_out[LPC_A0] == LPC_PAIR_OFF)
		else $error("first channel not down");
	chk_first_data0: assert property (panel_power_on_in && first_channel_activity_in == LPC_ACT_DATA0
		|=> pair_state_out[LPC_A2] == LPC_PAIR_ZERO && pair_state_out[LPC_FIRST_CLOCK_PAIR] == LPC_PAIR_ACTIVE)
		else $error("data zero level wrong");
	chk_first_active: assert property (panel_power_on_in && first_channel_activity_in == LPC_ACT_ACTIVE
		|=> pair_state_out[LPC_A1] == LPC_PAIR_ACTIVE && pair_state_out[LPC_FIRST_CLOCK_PAIR] == LPC_PAIR_ACTIVE)
		else $error("first channel not active");

	// eighth-bit pairs
	chk_eight_mode: assert property (eighth_bit_pair_activity_in == LPC_ACT_ACTIVE |=> eight_bit_mode_out)
		else $error("eight bit mode missing");
	chk_eight_off: assert property (eighth_bit_pair_activity_in == LPC_ACT_DOWN |=> !eight_bit_mode_out)
		else $error("eight bit mode without eighth pairs");
	chk_eighth_gate: assert property (panel_power_on_in && second_channel_activity_in == LPC_ACT_DOWN
		|=> pair_state_out[LPC_B3] == LPC_PAIR_OFF && pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_OFF)
		else $error("second channel not down");
	chk_eighth_min: assert property (panel_power_on_in && first_channel_activity_in == LPC_ACT_DATA0
		&& eighth_bit_pair_activity_in == LPC_ACT_ACTIVE |=> pair_state_out[LPC_A3] == LPC_PAIR_ZERO)
		else $error("eighth pair above its channel cap");
	chk_eighth_down: assert property (panel_power_on_in && eighth_bit_pair_activity_in == LPC_ACT_DOWN
		|=> pair_state_out[LPC_A3] == LPC_PAIR_OFF && pair_state_out[LPC_B3] == LPC_PAIR_OFF)
		else $error("eighth pairs not down");
	chk_eighth_data0: assert property (panel_power_on_in && eighth_bit_pair_activity_in == LPC_ACT_DATA0
		&& first_channel_activity_in == LPC_ACT_ACTIVE |=> pair_state_out[LPC_A3] == LPC_PAIR_ZERO)
		else $error("eighth pair data zero wrong");
	chk_eighth_active: assert property (panel_power_on_in && eighth_bit_pair_activity_in == LPC_ACT_ACTIVE
		&& first_channel_activity_in == LPC_ACT_ACTIVE && second_channel_activity_in == LPC_ACT_ACTIVE
		|=> pair_state_out[LPC_A3] == LPC_PAIR_ACTIVE && pair_state_out[LPC_B3] == LPC_PAIR_ACTIVE)
		else $error("eighth pairs not active");

	// second clock and two-channel mode
	chk_second_clock_pair_field: assert property (panel_power_on_in
		&& second_channel_activity_in == LPC_ACT_ACTIVE && second_clock_activity_in == LPC_ACT_DATA0
		|=> pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_ZERO)
		else $error("second clock level wrong");
	chk_second_clock_pair_down: assert property (panel_power_on_in
		&& second_channel_activity_in == LPC_ACT_ACTIVE && second_clock_activity_in == LPC_ACT_DOWN
		|=> pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_OFF)
		else $error("second clock not down");
	chk_second_clock_pair_single: assert property (panel_power_on_in
		&& second_channel_activity_in == LPC_ACT_DATA0 && second_clock_activity_in == LPC_ACT_ACTIVE
		|=> pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_ZERO && pair_state_out[LPC_B1] == LPC_PAIR_ZERO)
		else $error("second clock field used outside two-channel mode");
	chk_two_mode_on: assert property (second_channel_activity_in == LPC_ACT_ACTIVE
		|=> two_channel_mode_out)
		else $error("two-channel mode missing");
	chk_two_mode_off: assert property (second_channel_activity_in != LPC_ACT_ACTIVE
		|=> !two_channel_mode_out)
		else $error("two-channel mode without second channel");

	cov_two_channel: cover property (two_channel_mode_out && pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_ACTIVE);
	cov_tristate_off: cover property (pair_state_out[LPC_A0] == LPC_PAIR_HIZ);
	cov_power_cycle: cover property (!panel_power_on_in ##1 panel_power_on_in ##1 pair_state_out[LPC_A0] == LPC_PAIR_ACTIVE);
	cov_eighth_data0: cover property (eight_bit_mode_out && pair_state_out[LPC_A3] == LPC_PAIR_ZERO);
	cov_second_clock_pair_zero: cover property (two_channel_mode_out && pair_state_out[LPC_SECOND_CLOCK_PAIR] == LPC_PAIR_ZERO);
endmodule

// ### verilog/lpc_pkg.sv
// package for the lane power control block: field codes, pair states and fsm states
// assumes one display clock domain and synchronous active-low reset
package lpc_pkg;
	// activity field codes (2 bits)
	localparam logic [1:0] LPC_ACT_DOWN   = 2'h0;
	localparam logic [1:0] LPC_ACT_DATA0  = 2'h1;
	localparam logic [1:0] LPC_ACT_RSVD   = 2'h2;
	localparam logic [1:0] LPC_ACT_ACTIVE = 2'h3;
	// reserved-slot and idle-buffer selectors
	localparam logic       LPC_RSV_ZERO   = 1'h0;
	localparam logic       LPC_IDLE_ZERO  = 1'h0;
	// pair output states
	typedef enum logic [1:0] {
		LPC_PAIR_OFF     = 2'h0, // powered down (0V or common mode)
		LPC_PAIR_ZERO    = 2'h1, // powered, data forced to zero
		LPC_PAIR_ACTIVE  = 2'h3, // fully active
		LPC_PAIR_HIZ     = 2'h2  // tri-stated during sequenced power-down
	} lpc_pair_t;
	// pair indices
	localparam int LPC_NPAIR  = 10;
	localparam int LPC_A0     = 0;
	localparam int LPC_A1     = 1;
	localparam int LPC_A2     = 2;
	localparam int LPC_FIRST_CLOCK_PAIR   = 3;
	localparam int LPC_A3     = 4;
	localparam int LPC_B0     = 5;
	localparam int LPC_B1     = 6;
	localparam int LPC_B2     = 7;
	localparam int LPC_B3     = 8;
	localparam int LPC_SECOND_CLOCK_PAIR   = 9;
	// sequencer view: gray order off -> on
	typedef enum logic [1:0] {
		LPC_ST_OFF = 2'h0,
		LPC_ST_ON  = 2'h1
	} lpc_state_t;
	localparam logic [1:0] LPC_RST_FIELD = 2'h0;
endpackage

// ### testbench/lpc_panel_model.sv
// panel model: counts powered pairs and reports whether its clock runs
// assumes pair states arrive registered on the display clock
`timescale 1ns/1ps
module lpc_panel_model
	import lpc_pkg::*;
(
	// pairs from the transmitter
	input  wire lpc_pkg::lpc_pair_t pair_in [lpc_pkg::LPC_NPAIR],
	// what the panel sees
	output logic                    clock_seen_out,
	output logic [3:0]              powered_out
);
	always_comb begin
		powered_out = 4'h0;
		for (int i = 0; i < LPC_NPAIR; i++) begin
			powered_out += 4'((pair_in[i] == LPC_PAIR_ZERO) || (pair_in[i] == LPC_PAIR_ACTIVE));
		end
		clock_seen_out = (pair_in[LPC_FIRST_CLOCK_PAIR] == LPC_PAIR_ACTIVE);
	end
endmodule

// ### testbench/lpc_lane_power_tb.sv
// testbench for lane power control: reset, sweep of all legal field codes, mid-run reset
// assumes lpc_pkg, the design and the panel model are compiled first
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %0h seen %0h", nm, e, g); end end
module lpc_lane_power_tb;
	import lpc_pkg::*;
	logic       clk_sys_in = 1'b0;
	logic       rst_n_in = 1'b0;
	logic [1:0] f_in = 2'h0, e_in = 2'h0, c_in = 2'h0, s_in = 2'h0, dup_in = 2'h0;
	logic       idle_in = 1'b0, rsv_in = 1'b0, pwr_in = 1'b0;
	lpc_pair_t  pair_out [LPC_NPAIR];
	lpc_pair_t  exp_st [LPC_NPAIR];
	logic [1:0] slot_out;
	logic       eight_out, two_out, clk_seen;
	logic [3:0] powered;
	int         err_total = 0;
	int         num_checks = 0;
	initial forever #20 clk_sys_in = ~clk_sys_in;
	lpc_lane_power dut (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .first_channel_activity_in(f_in),
		.eighth_bit_pair_activity_in(e_in), .second_clock_activity_in(c_in), .second_channel_activity_in(s_in),
		.idle_tristate_sel_in(idle_in), .reserved_dup_sel_in(rsv_in), .panel_power_on_in(pwr_in),
		.dup_data_bit_in(dup_in), .pair_state_out(pair_out), .reserved_slot_out(slot_out),
		.eight_bit_mode_out(eight_out), .two_channel_mode_out(two_out));
	lpc_panel_model panel (.pair_in(pair_out), .clock_seen_out(clk_seen), .powered_out(powered));
	// lower of two caps; codes rank 00 < 01 < 11 since 10 is never written
	function automatic lpc_pair_t lvl(input logic [1:0] a, input logic [1:0] b);
		logic [1:0] m;
		m = (a < b) ? a : b;
		return (m == 2'h0) ? LPC_PAIR_OFF : ((m == 2'h1) ? LPC_PAIR_ZERO : LPC_PAIR_ACTIVE);
	endfunction
	task automatic apply_check(input logic [1:0] f, e, c, s, d, input logic idl, rsv, pwr);
		logic [3:0] n;
		@(posedge clk_sys_in);
		f_in <= f; e_in <= e; c_in <= c; s_in <= s; dup_in <= d;
		idle_in <= idl; rsv_in <= rsv; pwr_in <= pwr;
		repeat (2) @(posedge clk_sys_in);
		#1;
		n = 4'h0;
		for (int i = 0; i < 3; i++) begin
			exp_st[i] = lvl(f, 2'h3);
			exp_st[i + 5] = lvl(s, 2'h3);
		end
		exp_st[LPC_FIRST_CLOCK_PAIR] = (f == 2'h0) ? LPC_PAIR_OFF : LPC_PAIR_ACTIVE;
		exp_st[LPC_A3] = lvl(f, e);
		exp_st[LPC_B3] = lvl(s, e);
		exp_st[LPC_SECOND_CLOCK_PAIR] = (s == 2'h3) ? lvl(s, c) : lvl(s, s);
		for (int i = 0; i < LPC_NPAIR; i++) begin
			if (!pwr) begin
				exp_st[i] = idl ? LPC_PAIR_HIZ : LPC_PAIR_OFF;
			end
			n += 4'((exp_st[i] == LPC_PAIR_ZERO) || (exp_st[i] == LPC_PAIR_ACTIVE));
			`CHK("pair_state", exp_st[i], pair_out[i])
		end
		`CHK("panel_powered", n, powered)
		`CHK("panel_clock", exp_st[LPC_FIRST_CLOCK_PAIR] == LPC_PAIR_ACTIVE, clk_seen)
		`CHK("reserved_slot", rsv ? d : 2'h0, slot_out)
		`CHK("eight_bit_mode", e != 2'h0, eight_out)
		`CHK("two_channel_mode", s == 2'h3, two_out)
	endtask
	task automatic chk_reset();
		for (int i = 0; i < LPC_NPAIR; i++) begin
			`CHK("reset_pair", LPC_PAIR_OFF, pair_out[i])
		end
		`CHK("reset_slot", 2'h0, slot_out)
		`CHK("reset_flags", 2'h0, {eight_out, two_out})
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	initial begin
		logic [1:0] codes [3];
		logic [5:0] k;
		codes = '{2'h0, 2'h1, 2'h3};
		k = 6'h0;
		repeat (5) @(posedge clk_sys_in);
		#1 chk_reset();
		$display("test reset done");
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		foreach (codes[a]) foreach (codes[b]) foreach (codes[c]) foreach (codes[d]) begin
			apply_check(codes[a], codes[b], codes[c], codes[d], k[4:3], k[1], k[2], k % 3 != 0);
			k++;
		end
		$display("test sweep done");
		apply_check(2'h3, 2'h3, 2'h3, 2'h3, 2'h3, 1'b1, 1'b1, 1'b1);
		@(posedge clk_sys_in);
		rst_n_in <= 1'b0;
		repeat (2) @(posedge clk_sys_in);
		#1 chk_reset();
		@(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		apply_check(2'h1, 2'h3, 2'h0, 2'h1, 2'h2, 1'b0, 1'b1, 1'b1);
		$display("test midrun reset done");
		summarize();
	end
endmodule
